// >>> core/status_irq_unit.sv
// status latch and interrupt unit: momentary and sticky condition bits, masks, interrupt pin
// assumes condition inputs synchronous to hclk; one AHB-Lite master
//
// Functional notes
// - momentary bits are read-only and show live conditions at read time
// - each monitored condition also has a sticky latched bit set by its fault
// - latched bit stays set until software writes one; zero leaves it
// - clearing only works once the fault is gone, otherwise it sets again
// - each latched bit has an enable; zero masks it from the interrupt
// - all enables zero means the interrupt output never asserts
// - interrupt held while any enabled latched bit set, released when all cleared
// - manual mode: reference status is zero when the selected input is lost
// - automatic mode: zero only when every enabled reference is lost or disabled
// - holdover modes: zero while reference lost and PLL still in holdover
// - interrupt pin drives zero with no interrupt, one on unmasked set bit
// - pin polarity bit set to one inverts the interrupt pin
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module status_irq_unit
	import status_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [DATA_W-1:0] hwdata,
	input  wire logic              hready,
	output logic      [DATA_W-1:0] hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  cond_in_s               cond,
	output logic                   irq,
	output logic                   gpio_irq_pin
);

	//////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [NUM_COND-1:0] enable;
		cfg_s                cfg;
		logic                irq;
		logic                pin;
	} top_s;

	top_s                t_r;
	top_s                t_nxt;
	reg_wr_s             wr_req;
	reg_rd_s             rd_req;
	logic [DATA_W-1:0]   rdata;
	logic [NUM_COND-1:0] momentary;
	logic [NUM_COND-1:0] latched;
	logic [NUM_COND-1:0] clr;
	logic                ref_ok;
	logic                pending;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	//////////////////////////////////////////////////////////////////////////////
	// bus front end

	ahb_reg_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_req    (wr_req),
		.rd_req    (rd_req),
		.rdata     (rdata)
	);

	//////////////////////////////////////////////////////////////////////////////
	// reference validity, per selection mode

	always_comb begin
		ref_ok = 1'b1;
		unique case (t_r.cfg.mode)
			SEL_MANUAL: begin
				ref_ok = cond.clk_active[t_r.cfg.manual_sel];
			end
			SEL_AUTO: begin
				ref_ok = |(cond.clk_active & ~t_r.cfg.input_disable_bit);
			end
			SEL_SHORT_HOLD, SEL_AUTO_HOLD: begin
				ref_ok = !(!cond.clk_active[cond.active_ref] && cond.pll0_holdover);
			end
		endcase
	end

	// a one in every momentary bit means healthy, so a fault is its complement
	always_comb begin
		momentary = {ref_ok, !cond.pll0_holdover, cond.pll1_locked, cond.pll0_locked,
			cond.clk_active};
	end

	//////////////////////////////////////////////////////////////////////////////
	// sticky bits

	// clear is taken in the write data phase, one cycle after its address
	assign clr = (wr_req.wr && reg_hit(wr_req.addr, OFF_LATCHED)) ? wr_req.wdata[NUM_COND-1:0] : '0;

	sticky_bank #(
		.N (NUM_COND)
	) u_bank (
		.hclk    (hclk),
		.hresetn (hresetn),
		.fault   (~momentary),
		.clr     (clr),
		.latched (latched)
	);

	//////////////////////////////////////////////////////////////////////////////
	// register read mux; unmapped addresses read zero

	always_comb begin
		rdata = '0;
		if (reg_hit(rd_req.addr, OFF_MOMENTARY)) begin
			rdata[NUM_COND-1:0] = momentary;
		end else if (reg_hit(rd_req.addr, OFF_LATCHED)) begin
			rdata[NUM_COND-1:0] = latched;
		end else if (reg_hit(rd_req.addr, OFF_INT_ENABLE)) begin
			rdata[NUM_COND-1:0] = t_r.enable;
		end else if (reg_hit(rd_req.addr, OFF_CONFIG)) begin
			// field by field: the packed struct order is not the register layout
			rdata[CFG_MODE_LSB +: 2] = t_r.cfg.mode;
			rdata[CFG_SEL_LSB +: 2]  = t_r.cfg.manual_sel;
			rdata[CFG_DIS_LSB +: 4]  = t_r.cfg.input_disable_bit;
			rdata[CFG_INV_BIT]       = t_r.cfg.pin_output_invert;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// control registers and interrupt

	assign pending = |(latched & t_r.enable);

	always_comb begin
		t_nxt = t_r;
		if (wr_req.wr && reg_hit(wr_req.addr, OFF_INT_ENABLE)) begin
			t_nxt.enable = wr_req.wdata[NUM_COND-1:0];
		end
		if (wr_req.wr && reg_hit(wr_req.addr, OFF_CONFIG)) begin
			t_nxt.cfg.mode              = sel_mode_e'(wr_req.wdata[CFG_MODE_LSB +: 2]);
			t_nxt.cfg.manual_sel        = wr_req.wdata[CFG_SEL_LSB +: 2];
			t_nxt.cfg.input_disable_bit = wr_req.wdata[CFG_DIS_LSB +: 4];
			t_nxt.cfg.pin_output_invert = wr_req.wdata[CFG_INV_BIT];
		end
		// masked bits never reach the output, even while latched
		t_nxt.irq = pending;
		t_nxt.pin = pending ^ t_r.cfg.pin_output_invert;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t_r.enable <= RST_ENABLE;
			t_r.cfg    <= RST_CONFIG;
			t_r.irq    <= 1'b0;
			t_r.pin    <= 1'b0;
		end else begin
			t_r <= t_nxt;
		end
	end

	assign irq          = t_r.irq;
	assign gpio_irq_pin = t_r.pin;

	//////////////////////////////////////////////////////////////////////////////
	// checks

	// the pin lags the invert bit by one edge, so pin checks want it stable
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_live_read: assert property (
		(rd_req.rd && reg_hit(rd_req.addr, OFF_MOMENTARY))
		|=> (hrdata[NUM_COND-1:0] == $past(momentary)) && hreadyout
	) else $error("momentary read returned stale data");

	chk_fault_latches: assert property (
		(|(~momentary))
		|=> ((latched & $past(~momentary)) == $past(~momentary))
	) else $error("fault did not set its latched bit");

	chk_latch_holds: assert property (
		(|(latched & ~clr))
		|=> ((latched & $past(latched & ~clr)) == $past(latched & ~clr))
	) else $error("latched bit dropped without a clearing write");

	chk_clear_works: assert property (
		(|(clr & momentary))
		|=> ((latched & $past(clr & momentary)) == '0)
	) else $error("clearing write ignored with fault gone");

	chk_set_wins: assert property (
		(|(clr & ~momentary))
		|=> ((latched & $past(clr & ~momentary)) == $past(clr & ~momentary))
	) else $error("clear won over a present fault");

	chk_mask_gates: assert property (
		((latched & t_r.enable) == '0) |=> !irq
	) else $error("interrupt raised by masked bits only");

	chk_all_masked: assert property (
		(t_r.enable == '0) [*2] |-> !irq
	) else $error("interrupt with every enable zero");

	chk_irq_held: assert property (
		(|(latched & t_r.enable)) |=> irq
	) else $error("interrupt not held for enabled latched bit");

	chk_ref_manual: assert property (
		(t_r.cfg.mode == SEL_MANUAL) |-> (momentary[COND_REF] == cond.clk_active[t_r.cfg.manual_sel])
	) else $error("manual reference status wrong");

	chk_ref_auto: assert property (
		(t_r.cfg.mode == SEL_AUTO) |-> (momentary[COND_REF] == |(cond.clk_active & ~t_r.cfg.input_disable_bit))
	) else $error("automatic reference status wrong");

	chk_ref_holdover: assert property (
		(t_r.cfg.mode inside {SEL_SHORT_HOLD, SEL_AUTO_HOLD} && cond.pll0_holdover
			&& !cond.clk_active[cond.active_ref]) |-> !momentary[COND_REF]
	) else $error("holdover reference status not zero");

	chk_pin_level: assert property (
		(!t_r.cfg.pin_output_invert && $stable(t_r.cfg.pin_output_invert))
		|-> (gpio_irq_pin == irq)
	) else $error("interrupt pin level wrong");

	chk_pin_invert: assert property (
		##1 (gpio_irq_pin == (irq ^ $past(t_r.cfg.pin_output_invert)))
	) else $error("interrupt pin polarity wrong");

	chk_read_wait: assert property (
		rd_req.rd |-> !hreadyout ##1 hreadyout
	) else $error("read wait state not exactly one cycle");

	chk_write_ready: assert property (
		wr_req.wr |-> hreadyout
	) else $error("write data phase stalled");

	chk_latched_read: assert property (
		(rd_req.rd && reg_hit(rd_req.addr, OFF_LATCHED))
		|=> (hrdata[NUM_COND-1:0] == $past(latched))
	) else $error("latched read returned wrong bits");

	chk_enable_write: assert property (
		(wr_req.wr && reg_hit(wr_req.addr, OFF_INT_ENABLE))
		|=> (t_r.enable == $past(wr_req.wdata[NUM_COND-1:0]))
	) else $error("enable write did not land");

	chk_pin_inverted: assert property (
		(t_r.cfg.pin_output_invert && $stable(t_r.cfg.pin_output_invert))
		|-> (gpio_irq_pin == !irq)
	) else $error("inverted interrupt pin level wrong");

	chk_config_readback: assert property (
		(rd_req.rd && reg_hit(rd_req.addr, OFF_CONFIG))
		|=> (hrdata[CFG_INV_BIT] == $past(t_r.cfg.pin_output_invert))
			&& (hrdata[CFG_MODE_LSB +: 2] == $past(t_r.cfg.mode))
	) else $error("config read back out of place");

	chk_holdover_valid: assert property (
		(t_r.cfg.mode inside {SEL_SHORT_HOLD, SEL_AUTO_HOLD}
			&& (cond.clk_active[cond.active_ref] || !cond.pll0_holdover)) |-> momentary[COND_REF]
	) else $error("holdover reference status not one");

	chk_auto_all_lost: assert property (
		(t_r.cfg.mode == SEL_AUTO && (cond.clk_active & ~t_r.cfg.input_disable_bit) == '0)
		|-> !momentary[COND_REF]
	) else $error("automatic reference status not zero");

	cov_clear_with_fault: cover property (
		(|(clr & ~momentary))
	);

	cov_irq_rise: cover property (
		!irq ##1 irq
	);

	cov_irq_release: cover property (
		irq ##1 !irq
	);

	cov_read_momentary: cover property (
		rd_req.rd && reg_hit(rd_req.addr, OFF_MOMENTARY)
	);

	cov_manual_ref_lost: cover property (
		(t_r.cfg.mode == SEL_MANUAL) && !momentary[COND_REF]
	);

endmodule : status_irq_unit

// >>> core/status_pkg.sv
// shared constants, field layouts and carriers of the status latch and interrupt unit
// assumes one 125 MHz clock and a single AHB-Lite master with word accesses only
package status_pkg;

	localparam int              NUM_COND  = 8;
	localparam int              ADDR_W    = 8;
	localparam int              DATA_W    = 32;

	//////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_MOMENTARY  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LATCHED    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CONFIG     = 8'h0c;

	//////////////////////////////////////////////////////////////////////////////
	// condition bit positions, shared by momentary, latched and enable registers
	localparam int              COND_CLK0      = 0;
	localparam int              COND_PLL0_LOCK = 4;
	localparam int              COND_PLL1_LOCK = 5;
	localparam int              COND_PLL0_HOLD = 6;
	localparam int              COND_REF       = 7;

	// config register fields
	localparam int              CFG_MODE_LSB   = 0;
	localparam int              CFG_SEL_LSB    = 2;
	localparam int              CFG_DIS_LSB    = 4;
	localparam int              CFG_INV_BIT    = 8;

	// values after reset
	localparam logic [NUM_COND-1:0] RST_LATCHED = 8'h00;
	localparam logic [NUM_COND-1:0] RST_ENABLE  = 8'h00;
	localparam logic [8:0]          RST_CONFIG  = 9'h000;

	typedef enum logic [1:0] {
		SEL_MANUAL     = 2'h0,
		SEL_AUTO       = 2'h1,
		SEL_SHORT_HOLD = 2'h2,
		SEL_AUTO_HOLD  = 2'h3
	} sel_mode_e;

	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_wr_s;

	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] addr;
	} reg_rd_s;

	typedef struct packed {
		logic [3:0] clk_active;
		logic       pll0_locked;
		logic       pll1_locked;
		logic       pll0_holdover;
		logic [1:0] active_ref;
	} cond_in_s;

	typedef struct packed {
		sel_mode_e  mode;
		logic [1:0] manual_sel;
		logic [3:0] input_disable_bit;
		logic       pin_output_invert;
	} cfg_s;

endpackage : status_pkg

// >>> core/ahb_reg_slave.sv
// AHB-Lite slave front end: hands writes and reads of whole words to the register file
// assumes it is the only slave, so hreadyout is the bus hready
`timescale 1ns/1ps
module ahb_reg_slave
	import status_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [DATA_W-1:0] hwdata,
	input  wire logic              hready,
	output logic      [DATA_W-1:0] hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output reg_wr_s                wr_req,
	output reg_rd_s                rd_req,
	input  wire logic [DATA_W-1:0] rdata
);

	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WDATA = 3'b010,
		BUS_RWAIT = 3'b100
	} bus_state_e;

	typedef struct packed {
		bus_state_e        st;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] hrdata;
		logic              hreadyout;
	} slave_s;

	slave_s s_r;
	slave_s s_nxt;
	logic   accept;

	// hsize is not checked: only whole-word single transfers are issued
	assign accept = hsel && htrans[1] && hready;

	always_comb begin
		s_nxt = s_r;
		s_nxt.hreadyout = 1'b1;
		s_nxt.st = BUS_IDLE;
		if (s_r.st == BUS_RWAIT) begin
			// one wait state so a read sees writes committed just before it
			s_nxt.hrdata = rdata;
		end else if (accept) begin
			s_nxt.addr = haddr;
			if (hwrite) begin
				s_nxt.st = BUS_WDATA;
			end else begin
				s_nxt.st = BUS_RWAIT;
				s_nxt.hreadyout = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{st: BUS_IDLE, addr: '0, hrdata: '0, hreadyout: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata       = s_r.hrdata;
	assign hreadyout    = s_r.hreadyout;
	assign hresp        = 1'b0;
	assign wr_req.wr    = (s_r.st == BUS_WDATA);
	assign wr_req.addr  = s_r.addr;
	assign wr_req.wdata = hwdata;
	assign rd_req.rd    = (s_r.st == BUS_RWAIT);
	assign rd_req.addr  = s_r.addr;

endmodule : ahb_reg_slave

// >>> core/sticky_bank.sv
// bank of sticky fault bits, set by a fault level and cleared by a write-one pulse
// assumes fault levels are synchronous to hclk
`timescale 1ns/1ps
module sticky_bank
	import status_pkg::*;
#(
	parameter int N = NUM_COND
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [N-1:0] fault,
	input  wire logic [N-1:0] clr,
	output logic      [N-1:0] latched
);

	typedef struct packed {
		logic [N-1:0] bits;
	} bank_s;

	bank_s b_r;
	bank_s b_nxt;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			// a persisting fault re-sets the bit, so set wins over clear
			always_comb begin
				b_nxt.bits[i] = fault[i] | (b_r.bits[i] & ~clr[i]);
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			b_r <= '{bits: '0};
		end else begin
			b_r <= b_nxt;
		end
	end

	assign latched = b_r.bits;

endmodule : sticky_bank

// >>> verif/status_irq_unit_tb.sv
// testbench of the status latch and interrupt unit: register accesses and pin checks
// assumes one AHB-Lite master, hready looped back from hreadyout, conditions driven here
`timescale 1ns/1ps
module status_irq_unit_tb;
	import status_pkg::*;

	logic              hclk;
	logic              hresetn;
	logic              hsel;
	logic [ADDR_W-1:0] haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [DATA_W-1:0] hwdata;
	logic [DATA_W-1:0] hrdata;
	logic              hreadyout;
	logic              hresp;
	cond_in_s          cond;
	logic              irq;
	logic              gpio_irq_pin;
	logic [DATA_W-1:0] rd_q;
	int                mismatches;
	int                comparisons;
	int                cycles;
	// all inputs active, both plls locked, no holdover
	localparam logic [8:0] GOOD = 9'h1f8;
	logic [31:0]       m_cfg [8] = '{32'h08, 32'h08, 32'h01, 32'h81, 32'h01, 32'h02, 32'h02, 32'h03};
	logic [8:0]        m_cnd [8] = '{9'h098, 9'h178, 9'h018, 9'h118, 9'h118, 9'h01d, 9'h019, 9'h05d};
	logic              m_exp [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	status_irq_unit dut_u (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hreadyout),
		.hrdata       (hrdata),
		.hreadyout    (hreadyout),
		.hresp        (hresp),
		.cond         (cond),
		.irq          (irq),
		.gpio_irq_pin (gpio_irq_pin)
	);

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// hang guard: the whole sequence needs under two hundred cycles
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// hready only moves on rising edges, so the mid-cycle value is what the edge samples
	task automatic wait_ready();
		logic rdy;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			rd_q = hrdata;
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask : wait_ready

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rd_q, exp);
	endtask : rd

	// a fault lasting one cycle, then healthy conditions again
	task automatic pulse(input logic [8:0] c);
		cond <= cond_in_s'(c);
		@(posedge hclk);
		cond <= cond_in_s'(GOOD);
		repeat (2) @(posedge hclk);
	endtask : pulse

	task automatic pin_chk(input logic ei, input logic ep);
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		check("irq", {31'h0, irq}, {31'h0, ei});
		check("gpio_irq_pin", {31'h0, gpio_irq_pin}, {31'h0, ep});
		@(posedge hclk);
	endtask : pin_chk

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cond = cond_in_s'(GOOD);
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, read-only and unmapped places
		rd("config", OFF_CONFIG, 32'h0);
		rd("enable", OFF_INT_ENABLE, 32'h0);
		rd("latched", OFF_LATCHED, 32'h0);
		wr(OFF_MOMENTARY, 32'h0);
		rd("momentary", OFF_MOMENTARY, 32'hff);
		wr(8'h10, 32'hffffffff);
		rd("unmapped", 8'h10, 32'h0);
		check("hresp", {31'h0, hresp}, 32'h0);
		// faults held: live bits, sticky copies, no interrupt while all masked
		cond <= cond_in_s'(9'h14c);
		@(posedge hclk);
		rd("momentary", OFF_MOMENTARY, 32'h2a);
		rd("latched", OFF_LATCHED, 32'hd5);
		pin_chk(1'b0, 1'b0);
		wr(OFF_LATCHED, 32'hff);
		rd("latched", OFF_LATCHED, 32'hd5);
		rd("latched", OFF_LATCHED, 32'hd5);
		cond <= cond_in_s'(GOOD);
		@(posedge hclk);
		wr(OFF_LATCHED, 32'h0);
		rd("latched", OFF_LATCHED, 32'hd5);
		wr(OFF_LATCHED, 32'h01);
		rd("latched", OFF_LATCHED, 32'hd4);
		wr(OFF_LATCHED, 32'hd4);
		rd("latched", OFF_LATCHED, 32'h0);
		// masking, holding and polarity of the interrupt pin
		wr(OFF_INT_ENABLE, 32'h01);
		pulse(9'h178);
		pin_chk(1'b0, 1'b0);
		rd("latched", OFF_LATCHED, 32'h04);
		pulse(9'h1d8);
		pin_chk(1'b1, 1'b1);
		wr(OFF_CONFIG, 32'h100);
		rd("config", OFF_CONFIG, 32'h100);
		pin_chk(1'b1, 1'b0);
		wr(OFF_INT_ENABLE, 32'h05);
		wr(OFF_LATCHED, 32'h81);
		pin_chk(1'b1, 1'b0);
		wr(OFF_LATCHED, 32'h04);
		pin_chk(1'b0, 1'b1);
		wr(OFF_CONFIG, 32'h0);
		pin_chk(1'b0, 1'b0);
		wr(OFF_INT_ENABLE, 32'h0);
		// reference status in every selection mode
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CONFIG, m_cfg[i]);
			cond <= cond_in_s'(m_cnd[i]);
			@(posedge hclk);
			bus(1'b0, OFF_MOMENTARY, 32'h0);
			check("reference_valid_status", {31'h0, rd_q[COND_REF]}, {31'h0, m_exp[i]});
			rd("config", OFF_CONFIG, m_cfg[i]);
		end
		cond <= cond_in_s'(GOOD);
		@(posedge hclk);
		wr(OFF_CONFIG, 32'h0);
		wr(OFF_LATCHED, 32'hff);
		rd("latched", OFF_LATCHED, 32'h0);
		give_verdict();
	end

endmodule : status_irq_unit_tb
